// [hdl/bsf_pkg.sv]
// Purpose: Shared constants and carriers for the biosignal status flags block
// Assumes: 250 MHz device clock, serial frame of 8 command and 24 data bits
// Notes:   Status layout follows the 24-bit event status word
package bsf_pkg;

   // Device clock and persistence times
   localparam int unsigned CLK_KHZ      = 250000;
   localparam int unsigned DCOFF_MS     = 90;
   localparam int unsigned OVER_MS      = 100;
   localparam int unsigned UNDER_MS     = 128;
   localparam int unsigned DRIVE_MS     = 128;
   // DC detach is strictly more than its time, so one cycle beyond it
   localparam int unsigned DCOFF_CYC    = DCOFF_MS * CLK_KHZ + 1;
   localparam int unsigned OVER_CYC     = OVER_MS * CLK_KHZ;
   localparam int unsigned UNDER_CYC    = UNDER_MS * CLK_KHZ;
   localparam int unsigned DRIVE_CYC    = DRIVE_MS * CLK_KHZ;
   localparam int unsigned FILT_W       = 26;
   localparam int unsigned NUM_FILT     = 5;
   localparam int unsigned PULSE_CYC    = 16;
   localparam int unsigned AGE_W        = 8;

   // Serial frame
   localparam logic [6:0] STATUS_ADDR   = 7'h01;
   localparam logic [5:0] CMD_BITS      = 6'h08;
   localparam logic [5:0] FRAME_BITS    = 6'h20;
   localparam int unsigned WORD_W       = 24;
   localparam int unsigned MASK_W       = 16;

   // Low-power attach detect modes that enable detection
   localparam logic [1:0] ATTACH_MODE_A = 2'h1;
   localparam logic [1:0] ATTACH_MODE_B = 2'h2;

   // Heartbeat clear modes
   localparam logic [1:0] HB_CLR_READ   = 2'h0;
   localparam logic [1:0] HB_CLR_RTOR   = 2'h1;
   localparam logic [1:0] HB_CLR_SELF   = 2'h2;

   // Tick divider masks, one per divider setting
   localparam logic [3:0] TICK_MASK0    = 4'h0;
   localparam logic [3:0] TICK_MASK1    = 4'h1;
   localparam logic [3:0] TICK_MASK2    = 4'h3;
   localparam logic [3:0] TICK_MASK3    = 4'hF;

   // Filter slots
   localparam int unsigned F_DC         = 0;
   localparam int unsigned F_OVER       = 1;
   localparam int unsigned F_UNDER      = 2;
   localparam int unsigned F_POS        = 3;
   localparam int unsigned F_NEG        = 4;

   typedef struct packed {
      logic       cardiac_fifo_level_flag;
      logic       cardiac_fifo_overrun_flag;
      logic       quick_recovery_flag;
      logic       dc_electrode_detach_flag;
      logic       impedance_fifo_level_flag;
      logic       impedance_fifo_overrun_flag;
      logic       impedance_above_range_flag;
      logic       impedance_below_range_flag;
      logic       drive_source_monitor_flag;
      logic [2:0] unused_hi;
      logic       electrode_attach_flag;
      logic       heartbeat_event_flag;
      logic       rate_tick_flag;
      logic       loop_unlocked_flag;
      logic [1:0] unused_lo;
      logic       drive_source_pos_detail;
      logic       drive_source_neg_detail;
      logic       pos_input_high_detail;
      logic       pos_input_low_detail;
      logic       neg_input_high_detail;
      logic       neg_input_low_detail;
   } bsf_status_s;

   typedef struct packed {
      logic [4:0] cardiac_fifo_threshold;
      logic [2:0] impedance_fifo_threshold;
      logic       quick_recovery_clear_mode;
      logic [1:0] heartbeat_clear_mode;
      logic       tick_clear_mode;
      logic [1:0] tick_rate_divider;
   } bsf_mngr_s;

   typedef struct packed {
      logic       dc_detach_raw;
      logic [3:0] dc_detail_raw;
      logic       above_raw;
      logic       below_raw;
      logic       drive_pos_raw;
      logic       drive_neg_raw;
      logic       attach_raw;
      logic       pll_unlocked;
      logic       channel_on;
   } bsf_det_s;

endpackage

// [hdl/bsf_status_flags.sv]
// Purpose: Collects event sources into the event status word read over the serial port
// Assumes: Detector, FIFO and config inputs are on sys_clk_in; serial pins are not
// Notes:   Serial mode 0, 7-bit address then read bit, 24 data bits msb first
// How it works
// - Bit 23 set while unread cardiac records exceed the programmed threshold.
// - Cardiac overrun sets bit 22 until FIFO reset or resync.
// - Bit 21 raised on quick recovery, clearing per its clear mode.
// - Bit 20 after DC detach over 90ms, held until status read.
// - Bit 19 set while impedance records exceed the impedance threshold.
// - Impedance overrun sets bit 18 until FIFO reset or resync.
// - Bit 17 after 100ms above high limit, held until status read.
// - Bit 16 after 128ms below low limit, held until status read.
// - Bit 15 when either drive source detached 128ms, held until read.
// - Bit 11 asserted when attach mode is written to 01 or 10.
// - Once armed, attach flag follows condition, then held until read.
// - Bit 10 raised per heartbeat event, cleared per two-bit clear mode.
// - Bit 9 pulses on divided sample tick, cleared per tick clear mode.
// - Bit 8 set while loop unlocked and powered, held until read.
// - Bits 5 and 4 report positive and negative drive detach detail.
// - Bits 3 to 0: pos high, pos low, neg high, neg low.
// - DC detail bits rise with bit 20 and are held until read.
// - Every flag shows in status regardless of interrupt masks.
// - Each active-low interrupt is the OR of its masked flags.
`timescale 1ns/1ns
module bsf_status_flags
   import bsf_pkg::*;
#(
   parameter int unsigned DCOFF_LIM = DCOFF_CYC,
   parameter int unsigned OVER_LIM  = OVER_CYC,
   parameter int unsigned UNDER_LIM = UNDER_CYC,
   parameter int unsigned DRIVE_LIM = DRIVE_CYC,
   parameter int unsigned PULSE_LIM = PULSE_CYC
)(
   // Clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   // Serial port pins
   input  wire logic              sclk_in,
   input  wire logic              csb_n_in,
   input  wire logic              sdi_in,
   output logic                   sdo_out,
   output logic                   sdo_oe_out,
   // FIFO events
   input  wire logic [5:0]        cardiac_fifo_count_in,
   input  wire logic [3:0]        impedance_fifo_count_in,
   input  wire logic              cardiac_overrun_in,
   input  wire logic              impedance_overrun_in,
   input  wire logic              fifo_reset_in,
   input  wire logic              resync_command_in,
   // Detectors and loop
   input  wire bsf_det_s          det_in,
   input  wire logic              quick_recovery_in,
   input  wire logic              heartbeat_in,
   input  wire logic              heartbeat_read_in,
   input  wire logic              sample_tick_in,
   // Configuration
   input  wire bsf_mngr_s         mngr_in,
   input  wire logic [1:0]        low_power_attach_detect_mode_in,
   input  wire logic              attach_mode_wr_in,
   input  wire logic [MASK_W-1:0] primary_irq_mask_in,
   input  wire logic [MASK_W-1:0] secondary_irq_mask_in,
   // Interrupts and status
   output logic                   primary_irq_out_n,
   output logic                   secondary_irq_out_n,
   output bsf_status_s            status_out
);

   // Serial pin synchronisers and edge history
   logic [2:0] sclk_q, sclk_d;
   logic [1:0] csb_q, csb_d;
   logic [1:0] sdi_q, sdi_d;
   logic       rise, fall;
   logic [5:0] cnt_q, cnt_d;
   logic [6:0] cmd_q, cmd_d;
   logic [WORD_W-1:0] tx_q, tx_d;
   logic       rd_stat_q, rd_stat_d;
   logic       rd_clr;

   always_comb
   begin
      sclk_d    = {sclk_q[1:0], sclk_in};
      csb_d     = {csb_q[0], csb_n_in};
      sdi_d     = {sdi_q[0], sdi_in};
      rise      = sclk_q[1] & ~sclk_q[2];
      fall      = ~sclk_q[1] & sclk_q[2];
      cnt_d     = cnt_q;
      cmd_d     = cmd_q;
      tx_d      = tx_q;
      rd_stat_d = rd_stat_q;
      rd_clr    = 1'b0;
      if (csb_q[1])
      begin
         cnt_d     = 6'h00;
         rd_stat_d = 1'b0;
      end
      else if (rise)
      begin
         if (cnt_q != 6'h3F)
            cnt_d = cnt_q + 6'h01;
         if (cnt_q < CMD_BITS - 6'h01)
            cmd_d = {cmd_q[5:0], sdi_q[1]};
         if (cnt_q == CMD_BITS - 6'h01)
         begin
            rd_stat_d = (cmd_q == STATUS_ADDR) & sdi_q[1];
            tx_d      = ((cmd_q == STATUS_ADDR) & sdi_q[1]) ? status_out : '0;
         end
         // Latched flags except the overruns and those set to another clear mode clear on the last serial clock of a status read
         if (cnt_q == FRAME_BITS - 6'h01 && rd_stat_q)
            rd_clr = 1'b1;
      end
      else if (fall && cnt_q > CMD_BITS)
         tx_d = {tx_q[WORD_W-2:0], 1'b0};
   end

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sclk_q    <= 3'h0;
         csb_q     <= 2'h3;
         sdi_q     <= 2'h0;
         cnt_q     <= 6'h00;
         cmd_q     <= 7'h00;
         tx_q      <= '0;
         rd_stat_q <= 1'b0;
      end
      else
      begin
         sclk_q    <= sclk_d;
         csb_q     <= csb_d;
         sdi_q     <= sdi_d;
         cnt_q     <= cnt_d;
         cmd_q     <= cmd_d;
         tx_q      <= tx_d;
         rd_stat_q <= rd_stat_d;
      end
   end

   assign sdo_out    = tx_q[WORD_W-1];
   assign sdo_oe_out = ~csb_q[1];

   // Persistence filters: DC detach, above, below, drive pos, drive neg
   localparam int unsigned LIM [NUM_FILT] = '{DCOFF_LIM, OVER_LIM, UNDER_LIM, DRIVE_LIM,
                                              DRIVE_LIM};
   logic [NUM_FILT-1:0] cond, qual;

   assign cond = {det_in.drive_neg_raw, det_in.drive_pos_raw, det_in.below_raw,
                  det_in.above_raw, det_in.dc_detach_raw};

   for (genvar i = 0; i < NUM_FILT; i++)
   begin : g_filt
      logic [FILT_W-1:0] fc_q, fc_d;
      always_comb
      begin
         fc_d = fc_q;
         if (!cond[i])
            fc_d = '0;
         else if (fc_q < FILT_W'(LIM[i]))
            fc_d = fc_q + FILT_W'(1);
      end
      always_ff @(posedge sys_clk_in or posedge reset_in)
      begin
         if (reset_in)
            fc_q <= '0;
         else
            fc_q <= fc_d;
      end
      assign qual[i] = cond[i] && fc_q >= FILT_W'(LIM[i]);
   end

   // Flag state
   bsf_status_s       st_q, st_d;
   logic              armed_q, armed_d;
   logic [3:0]        tdiv_q, tdiv_d;
   logic [AGE_W-1:0]  hb_age_q, hb_age_d, tk_age_q, tk_age_d;
   logic              irq1_q, irq1_d, irq2_q, irq2_d;
   logic              mode_en, tick_hit, hb_clr, tk_clr;
   logic [3:0]        tmask;
   logic [MASK_W-1:0] irq_src;

   always_comb
   begin
      st_d    = st_q;
      mode_en = low_power_attach_detect_mode_in == ATTACH_MODE_A ||
                low_power_attach_detect_mode_in == ATTACH_MODE_B;
      unique case (mngr_in.tick_rate_divider)
         2'h0: tmask = TICK_MASK0;
         2'h1: tmask = TICK_MASK1;
         2'h2: tmask = TICK_MASK2;
         2'h3: tmask = TICK_MASK3;
      endcase
      tdiv_d   = sample_tick_in ? tdiv_q + 4'h1 : tdiv_q;
      tick_hit = sample_tick_in && (tdiv_q & tmask) == 4'h0;
      hb_age_d = heartbeat_in ? '0 : (hb_age_q < AGE_W'(PULSE_LIM) ? hb_age_q + AGE_W'(1)
                                                                 : hb_age_q);
      tk_age_d = tick_hit ? '0 : (tk_age_q < AGE_W'(PULSE_LIM) ? tk_age_q + AGE_W'(1)
                                                             : tk_age_q);
      // Level flags follow the FIFO fill against threshold plus one
      st_d.cardiac_fifo_level_flag =
         cardiac_fifo_count_in >= {1'b0, mngr_in.cardiac_fifo_threshold} + 6'h01;
      st_d.impedance_fifo_level_flag =
         impedance_fifo_count_in >= {1'b0, mngr_in.impedance_fifo_threshold} + 4'h1;
      // Overrun held until FIFO reset or resync; a new overrun wins
      st_d.cardiac_fifo_overrun_flag = cardiac_overrun_in |
         (st_q.cardiac_fifo_overrun_flag & ~(fifo_reset_in | resync_command_in));
      st_d.impedance_fifo_overrun_flag = impedance_overrun_in |
         (st_q.impedance_fifo_overrun_flag & ~(fifo_reset_in | resync_command_in));
      st_d.quick_recovery_flag = mngr_in.quick_recovery_clear_mode ? quick_recovery_in
         : quick_recovery_in | (st_q.quick_recovery_flag & ~rd_clr);
      st_d.dc_electrode_detach_flag = qual[F_DC] |
         (st_q.dc_electrode_detach_flag & ~rd_clr);
      st_d.impedance_above_range_flag = qual[F_OVER] |
         (st_q.impedance_above_range_flag & ~rd_clr);
      st_d.impedance_below_range_flag = qual[F_UNDER] |
         (st_q.impedance_below_range_flag & ~rd_clr);
      st_d.drive_source_pos_detail = qual[F_POS] | (st_q.drive_source_pos_detail & ~rd_clr);
      st_d.drive_source_neg_detail = qual[F_NEG] | (st_q.drive_source_neg_detail & ~rd_clr);
      st_d.drive_source_monitor_flag = qual[F_POS] | qual[F_NEG] |
         (st_q.drive_source_monitor_flag & ~rd_clr);
      {st_d.pos_input_high_detail, st_d.pos_input_low_detail,
       st_d.neg_input_high_detail, st_d.neg_input_low_detail} =
         ({4{qual[F_DC]}} & det_in.dc_detail_raw) |
         ({st_q.pos_input_high_detail, st_q.pos_input_low_detail,
           st_q.neg_input_high_detail, st_q.neg_input_low_detail} & {4{~rd_clr}});
      // Attach detect armed by the first status read after enabling
      armed_d = mode_en & (armed_q | rd_clr);
      st_d.electrode_attach_flag = (attach_mode_wr_in & mode_en) |
         (armed_q & det_in.attach_raw) | (st_q.electrode_attach_flag & ~rd_clr);
      unique case (mngr_in.heartbeat_clear_mode)
         HB_CLR_RTOR: hb_clr = heartbeat_read_in;
         HB_CLR_SELF: hb_clr = hb_age_q == AGE_W'(PULSE_LIM - 1);
         default:     hb_clr = rd_clr;
      endcase
      st_d.heartbeat_event_flag = heartbeat_in | (st_q.heartbeat_event_flag & ~hb_clr);
      tk_clr = mngr_in.tick_clear_mode ? tk_age_q == AGE_W'(PULSE_LIM - 1) : rd_clr;
      st_d.rate_tick_flag = tick_hit | (st_q.rate_tick_flag & ~tk_clr);
      st_d.loop_unlocked_flag = (det_in.channel_on & det_in.pll_unlocked) |
         (st_q.loop_unlocked_flag & ~rd_clr);
      st_d.unused_hi = 3'h0;
      st_d.unused_lo = 2'h0;
      // Masks gate only the interrupt pins, never the status word
      irq1_d = ~|(irq_src & primary_irq_mask_in);
      irq2_d = ~|(irq_src & secondary_irq_mask_in);
   end

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         st_q     <= '0;
         armed_q  <= 1'b0;
         tdiv_q   <= 4'h0;
         hb_age_q <= '0;
         tk_age_q <= '0;
         irq1_q   <= 1'b1;
         irq2_q   <= 1'b1;
      end
      else
      begin
         st_q     <= st_d;
         armed_q  <= armed_d;
         tdiv_q   <= tdiv_d;
         hb_age_q <= hb_age_d;
         tk_age_q <= tk_age_d;
         irq1_q   <= irq1_d;
         irq2_q   <= irq2_d;
      end
   end

   assign status_out          = st_q;
   assign irq_src             = st_q[WORD_W-1 -: MASK_W];
   assign primary_irq_out_n   = irq1_q;
   assign secondary_irq_out_n = irq2_q;

   property p_level;
      @(posedge sys_clk_in) disable iff (reset_in)
      st_q.cardiac_fifo_level_flag == ($past(cardiac_fifo_count_in) >=
         {1'b0, $past(mngr_in.cardiac_fifo_threshold)} + 6'h01);
   endproperty
   a_level: assert property (p_level) else $error("cardiac level flag wrong");

   property p_ovf;
      @(posedge sys_clk_in) disable iff (reset_in)
      st_q.cardiac_fifo_overrun_flag && !fifo_reset_in && !resync_command_in |=>
         st_q.cardiac_fifo_overrun_flag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overrun flag lost");

   property p_dc;
      @(posedge sys_clk_in) disable iff (reset_in)
      $rose(st_q.dc_electrode_detach_flag) |-> $past(qual[F_DC]);
   endproperty
   a_dc: assert property (p_dc) else $error("detach flag without filter");

   property p_attach;
      @(posedge sys_clk_in) disable iff (reset_in)
      attach_mode_wr_in && mode_en |=> st_q.electrode_attach_flag;
   endproperty
   a_attach: assert property (p_attach) else $error("attach flag not set");

   property p_hb;
      @(posedge sys_clk_in) disable iff (reset_in)
      heartbeat_in |=> st_q.heartbeat_event_flag ##1 st_q.heartbeat_event_flag ||
         mngr_in.heartbeat_clear_mode != HB_CLR_READ || rd_clr;
   endproperty
   a_hb: assert property (p_hb) else $error("heartbeat flag not held");

   property p_detail;
      @(posedge sys_clk_in) disable iff (reset_in)
      $rose(st_q.pos_input_high_detail) |-> $rose(st_q.dc_electrode_detach_flag) ||
         st_q.dc_electrode_detach_flag;
   endproperty
   a_detail: assert property (p_detail) else $error("detail without detach");

   property p_irq;
      @(posedge sys_clk_in) disable iff (reset_in)
      ##1 primary_irq_out_n == !(|($past(irq_src) & $past(primary_irq_mask_in)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt pin mismatch");

   property p_zero;
      @(posedge sys_clk_in) disable iff (reset_in)
      status_out.unused_hi == 3'h0 && status_out.unused_lo == 2'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("unused bits not zero");

   property p_pll;
      @(posedge sys_clk_in) disable iff (reset_in)
      det_in.channel_on && det_in.pll_unlocked |=> st_q.loop_unlocked_flag;
   endproperty
   a_pll: assert property (p_pll) else $error("unlock flag not set");

endmodule

// [tb/bsf_host_model.sv]
// Purpose: Host side of the serial port, issues status frames
// Assumes: Pins change on sys_clk_in edges, link period 80 ns
// Notes:   Mode 0, sclk idles low, sdi toggles once command is sent
`timescale 1ns/1ns
module bsf_host_model (
   // Clock
   input  wire logic sys_clk_in,
   // Serial pins
   output logic      sclk_out,
   output logic      csb_n_out,
   output logic      sdi_out,
   input  wire logic sdo_in
);
   initial
   begin
      sclk_out = 1'h0;
      csb_n_out = 1'h1;
      sdi_out = 1'h0;
   end

   // Half of the 80 ns link period
   task automatic half();
      repeat (10) @(posedge sys_clk_in);
   endtask

   // Command msb first, then 24 data bits sampled on rises
   task automatic frame(input logic [7:0] cmd, output logic [23:0] data);
      data = 24'h0;
      @(posedge sys_clk_in);
      csb_n_out <= 1'h0;
      half();
      for (int i = 0; i < 32; i++)
      begin
         sdi_out <= (i < 8) ? cmd[7-i] : ~sdi_out;
         half();
         sclk_out <= 1'h1;
         if (i >= 8)
            data[31-i] = sdo_in;
         half();
         sclk_out <= 1'h0;
      end
      half();
      csb_n_out <= 1'h1;
      sdi_out <= 1'h0;
      half();
   endtask
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the status flags block
// Assumes: Short persistence limits, host model reads over serial
// Notes:   Table covers level flags, hand tests cover latched ones
`timescale 1ns/1ns
module tb_top
   import bsf_pkg::*;
;
   typedef struct {
      logic [5:0]  cc;
      logic [4:0]  ct;
      logic [3:0]  ic;
      logic [2:0]  it;
      logic [2:0]  qpo;
      logic [23:0] ex;
   } bsf_row_s;
   bsf_row_s rows[4] = '{
      '{6'h05, 5'h04, 4'h3, 3'h2, 3'h2, 24'h880000},
      '{6'h04, 5'h04, 4'h2, 3'h2, 3'h5, 24'h200000},
      '{6'h20, 5'h1F, 4'h8, 3'h7, 3'h0, 24'h880000},
      '{6'h1F, 5'h1F, 4'h7, 3'h7, 3'h7, 24'h200100}};
   localparam int PL_L = 16;
   logic        sys_clk = 1'h0;
   logic        rst = 1'h1;
   logic        sclk, csb_n, sdi, sdo, sdo_oe, irq1_n, irq2_n;
   logic [5:0]  ccnt = 6'h00;
   logic [3:0]  icnt = 4'h0;
   logic        c_ovr = 1'h0, i_ovr = 1'h0, f_rst = 1'h0, rsync = 1'h0;
   logic        quick = 1'h0, hb = 1'h0, hb_rd = 1'h0, tick = 1'h0;
   logic [1:0]  amode = 2'h0;
   logic        awr = 1'h0;
   logic [15:0] mask1 = 16'h0004, mask2 = 16'h0002;
   bsf_det_s    det = '0;
   bsf_mngr_s   mngr = '0;
   bsf_status_s st;
   logic [23:0] d;
   int          err_total = 0, samples_checked = 0, hits, cyc_n = 0;

   always #2 sys_clk = ~sys_clk;

   bsf_status_flags #(.DCOFF_LIM(20), .OVER_LIM(12), .UNDER_LIM(16), .DRIVE_LIM(16),
      .PULSE_LIM(PL_L)) dut (
      .sys_clk_in(sys_clk), .reset_in(rst), .sclk_in(sclk), .csb_n_in(csb_n),
      .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .cardiac_fifo_count_in(ccnt),
      .impedance_fifo_count_in(icnt), .cardiac_overrun_in(c_ovr),
      .impedance_overrun_in(i_ovr), .fifo_reset_in(f_rst), .resync_command_in(rsync),
      .det_in(det), .quick_recovery_in(quick), .heartbeat_in(hb),
      .heartbeat_read_in(hb_rd), .sample_tick_in(tick), .mngr_in(mngr),
      .low_power_attach_detect_mode_in(amode), .attach_mode_wr_in(awr),
      .primary_irq_mask_in(mask1), .secondary_irq_mask_in(mask2),
      .primary_irq_out_n(irq1_n), .secondary_irq_out_n(irq2_n), .status_out(st));

   bsf_host_model host (.sys_clk_in(sys_clk), .sclk_out(sclk), .csb_n_out(csb_n),
      .sdi_out(sdi), .sdo_in(sdo));

   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] ex);
      samples_checked++;
      if (seen !== ex)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic complete_run();
      $display("Counts: %0d checked, %0d mismatches", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk)
   begin
      cyc_n++;
      if (cyc_n == 60000)
      begin
         err_total++;
         complete_run();
      end
   end

   initial
   begin
      cyc(8);
      check("reset status", st, 24'h0);
      check("reset pins", {20'h0, irq1_n, irq2_n, sdo_oe, sdo}, 24'hC);
      $display("Test done: reset");
      rst <= 1'h0;
      mngr.quick_recovery_clear_mode <= 1'h1;
      cyc(4);
      foreach (rows[i])
      begin
         ccnt <= rows[i].cc;
         icnt <= rows[i].ic;
         mngr.cardiac_fifo_threshold <= rows[i].ct;
         mngr.impedance_fifo_threshold <= rows[i].it;
         {quick, det.pll_unlocked, det.channel_on} <= rows[i].qpo;
         cyc(3);
         check("level flags", st & 24'hA80100, rows[i].ex);
         check("unused bits", st & 24'h0070C0, 24'h0);
      end
      {quick, det.pll_unlocked} <= 2'h0;
      mngr.quick_recovery_clear_mode <= 1'h0;
      cyc(3);
      check("loop latched", {st[21], st[8]}, 24'h3);
      host.frame(8'h03, d);
      check("read unused", d & 24'h0070C0, 24'h0);
      check("loop read", {d[21], d[8], st[21], st[8]}, 24'hC);
      $display("Test done: level table");
      for (int k = 0; k < 2; k++)
      begin
         {c_ovr, i_ovr} <= 2'h3;
         cyc(1);
         {c_ovr, i_ovr} <= 2'h0;
         cyc(3);
         host.frame(8'h03, d);
         check("overrun kept", st & 24'h440000, 24'h440000);
         if (k == 0)
            f_rst <= 1'h1;
         else
            rsync <= 1'h1;
         cyc(1);
         {f_rst, rsync} <= 2'h0;
         cyc(3);
         check("overrun cleared", st & 24'h440000, 24'h0);
      end
      $display("Test done: overrun");
      det.dc_detail_raw <= 4'hA;
      for (int k = 0; k < 2; k++)
      begin
         {det.dc_detach_raw, det.above_raw, det.below_raw, det.drive_pos_raw} <= 4'hF;
         cyc(k ? 30 : 8);
         {det.dc_detach_raw, det.above_raw, det.below_raw, det.drive_pos_raw} <= 4'h0;
         cyc(3);
         check("persist", st & 24'h13803F, k ? 24'h13802A : 24'h0);
      end
      host.frame(8'h03, d);
      check("persist read", d & 24'h13803F, 24'h13802A);
      check("persist clear", st & 24'h13803F, 24'h0);
      $display("Test done: persistence");
      for (int m = 1; m < 3; m++)
      begin
         amode <= m[1:0];
         awr <= 1'h1;
         cyc(1);
         awr <= 1'h0;
         cyc(3);
         check("attach on enable", st[11], 24'h1);
         host.frame(8'h03, d);
         check("attach armed", st[11], 24'h0);
         det.attach_raw <= 1'h1;
         cyc(3);
         det.attach_raw <= 1'h0;
         cyc(3);
         check("attach held", st[11], 24'h1);
         host.frame(8'h03, d);
         check("attach cleared", st[11], 24'h0);
      end
      $display("Test done: attach");
      for (int m = 0; m < 4; m++)
      begin
         mngr.heartbeat_clear_mode <= m[1:0];
         hb <= 1'h1;
         cyc(1);
         hb <= 1'h0;
         cyc(2);
         check("heartbeat irq", {st[10], irq1_n, irq2_n}, 24'h5);
         if (m == 0)
         begin
            host.frame(8'h05, d);
            check("other address", d, 24'h0);
            host.frame(8'h02, d);
            check("write refused", st[10], 24'h1);
            host.frame(8'h03, d);
         end
         else if (m == 1)
         begin
            hb_rd <= 1'h1;
            cyc(1);
            hb_rd <= 1'h0;
         end
         else if (m == 3)
            host.frame(8'h03, d);
         else
            cyc(PL_L + 4);
         cyc(3);
         check("heartbeat clear", {st[10], irq1_n}, 24'h1);
      end
      $display("Test done: heartbeat");
      mngr.tick_clear_mode <= 1'h1;
      for (int dv = 0; dv < 4; dv++)
      begin
         mngr.tick_rate_divider <= dv[1:0];
         hits = 0;
         repeat (16)
         begin
            tick <= 1'h1;
            cyc(1);
            tick <= 1'h0;
            cyc(2);
            if (st[9] === 1'h1)
               hits++;
            cyc(PL_L + 4);
         end
         check("tick count", hits[23:0], dv == 3 ? 24'h1 : 24'h10 >> dv);
         check("tick cleared", st[9], 24'h0);
      end
      // Read-clear mode: tick flag held until a status read
      mngr.tick_clear_mode <= 1'h0;
      tick <= 1'h1;
      cyc(1);
      tick <= 1'h0;
      cyc(PL_L + 4);
      check("tick held", {st[9], irq2_n}, 24'h2);
      host.frame(8'h03, d);
      check("tick read", {d[9], st[9], irq2_n}, 24'h5);
      $display("Test done: tick");
      complete_run();
   end
endmodule
